/* File: rtl/bucket_pkg.sv */
// Package with register map, reset values and carriers for the leaky bucket monitor.
package bucket_pkg;
   // Register indices (printed offsets are not all multiples of four).
   localparam logic [7:0] IDX_UPPER  = 8'h50;
   localparam logic [7:0] IDX_CLEAR  = 8'h51;
   localparam logic [7:0] IDX_MAXF   = 8'h52;
   localparam logic [7:0] IDX_DECAY  = 8'h53;
   localparam logic [7:0] IDX_STATUS = 8'h60;
   localparam logic [7:0] IDX_MASK   = 8'h61;
   localparam logic [7:0] IDX_FILL   = 8'h62;
   // Reset values.
   localparam logic [7:0] RST_UPPER  = 8'h06;
   localparam logic [7:0] RST_CLEAR  = 8'h04;
   localparam logic [7:0] RST_MAXF   = 8'h08;
   localparam logic [1:0] RST_DECAY  = 2'h1;
   localparam logic [1:0] RST_MASK   = 2'h0;
   // Status bit positions.
   localparam int ST_RAISE = 0;
   localparam int ST_CLEAR = 1;
   // Monitoring cycle length in system clocks.
   localparam int CYCLE_NS   = 1000;
   localparam int CLK_NS     = 20;
   localparam int CYCLE_CLKS = CYCLE_NS / CLK_NS;

   typedef struct packed {
      logic [7:0] upper;
      logic [7:0] clear_level;
      logic [7:0] max_fill;
      logic [1:0] decay;
   } bucket_cfg_s;
endpackage

/* File: rtl/bucket_core.sv */
// Leaky bucket accumulator with hysteresis alarm.
`timescale 1ns/1ns
`default_nettype none
module bucket_core (
   // Clock and reset.
   input  wire logic               i_clk,
   input  wire logic               i_srst,
   // Monitoring strobes and configuration.
   input  wire logic               i_tick,
   input  wire logic               i_fault,
   input  wire bucket_pkg::bucket_cfg_s i_cfg,
   // State.
   output logic [7:0]              o_fill,
   output logic                    o_alarm,
   output logic                    o_raise_ev,
   output logic                    o_clear_ev
);
   logic [7:0] fill, next_fill;
   logic       alarm, next_alarm;
   logic [2:0] decay_cnt, next_decay_cnt;
   logic [2:0] decay_lim;

   always_comb begin
      decay_lim      = 3'((4'h1 << i_cfg.decay) - 4'h1);
      next_fill      = fill;
      next_alarm     = alarm;
      next_decay_cnt = decay_cnt;
      if (i_tick) begin
         if (i_fault) begin
            next_decay_cnt = 3'h0;
            if (fill < i_cfg.max_fill) begin
               next_fill = fill + 8'h01;
            end else begin
               next_fill = i_cfg.max_fill;
            end
         end else if (decay_cnt >= decay_lim) begin
            next_decay_cnt = 3'h0;
            if (fill != 8'h00) begin
               next_fill = fill - 8'h01;
            end
         end else begin
            next_decay_cnt = decay_cnt + 3'h1;
         end
      end
      if (!alarm && next_fill >= i_cfg.upper) begin
         next_alarm = 1'b1;
      end else if (alarm && next_fill <= i_cfg.clear_level) begin
         next_alarm = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         fill       <= 8'h00;
         alarm      <= 1'b0;
         decay_cnt  <= 3'h0;
         o_raise_ev <= 1'b0;
         o_clear_ev <= 1'b0;
      end else begin
         fill       <= next_fill;
         alarm      <= next_alarm;
         decay_cnt  <= next_decay_cnt;
         o_raise_ev <= next_alarm & ~alarm;
         o_clear_ev <= alarm & ~next_alarm;
      end
   end

   assign o_fill  = fill;
   assign o_alarm = alarm;
endmodule
`default_nettype wire

/* File: rtl/bucket_monitor.sv */
// Wishbone-attached leaky bucket activity monitor for one reference input.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Each monitoring cycle with a failed or erratic input adds one to the bucket.
// - Each fault-free decay period of 1, 2, 4 or 8 cycles subtracts one.
// - An active alarm clears when the bucket falls to the lower threshold.
// - Faults never grow the bucket past the maximum size; a fault at the limit holds the fill there and restarts the decay period.
// - Lower threshold resets to 0x04, maximum size to 0x08; both read/write.
module bucket_monitor (
   // Clock and reset.
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   // Wishbone slave.
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [31:0] i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic [31:0]      o_wb_dat,
   output logic             o_wb_ack,
   // Monitored input fault indication, from a pin.
   input  wire logic        i_fault,
   // Alarm and interrupt.
   output logic             o_alarm,
   output logic             o_irq
);
   bucket_pkg::bucket_cfg_s cfg, next_cfg;
   logic [1:0]  status, next_status, mask, next_mask;
   logic [31:0] rdata, next_rdata;
   logic        ack, next_ack;
   logic [5:0]  tick_cnt, next_tick_cnt;
   logic        tick;
   logic        fault_m, fault_s;
   logic [7:0]  fill;
   logic        alarm, raise_ev, clear_ev;
   logic        req;
   logic [7:0]  idx;
   logic        wr0;

   // The fault level crosses from the pin domain through two flops.
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         fault_m <= 1'b0;
         fault_s <= 1'b0;
      end else begin
         fault_m <= i_fault;
         fault_s <= fault_m;
      end
   end

   // Monitoring cycle divider.
   always_comb begin
      tick          = (tick_cnt == 6'(bucket_pkg::CYCLE_CLKS - 1));
      next_tick_cnt = tick ? 6'h00 : tick_cnt + 6'h01;
   end

   bucket_core bucket_core_i (
      .i_clk      (i_clk),
      .i_srst     (i_srst),
      .i_tick     (tick),
      .i_fault    (fault_s),
      .i_cfg      (cfg),
      .o_fill     (fill),
      .o_alarm    (alarm),
      .o_raise_ev (raise_ev),
      .o_clear_ev (clear_ev)
   );

   // Word index is byte address over four; only the low lane carries data, except the fill read, which puts the alarm in bit 8.
   always_comb begin
      req         = i_wb_cyc & i_wb_stb & ~ack;
      idx         = i_wb_adr[9:2];
      // A write commits at the edge where the master sees ack, while it still holds the request.
      wr0         = i_wb_cyc & i_wb_stb & ack & i_wb_we & i_wb_sel[0];
      next_ack    = req;
      next_cfg    = cfg;
      next_mask   = mask;
      next_rdata  = 32'h0000_0000;
      // Hardware set wins over a software clear in the same cycle.
      next_status = status;
      if (wr0 && idx == bucket_pkg::IDX_STATUS) begin
         next_status = status & ~i_wb_dat[1:0];
      end
      next_status[bucket_pkg::ST_RAISE] = next_status[bucket_pkg::ST_RAISE] | raise_ev;
      next_status[bucket_pkg::ST_CLEAR] = next_status[bucket_pkg::ST_CLEAR] | clear_ev;
      if (wr0) begin
         unique case (idx)
            bucket_pkg::IDX_UPPER: next_cfg.upper       = i_wb_dat[7:0];
            bucket_pkg::IDX_CLEAR: next_cfg.clear_level = i_wb_dat[7:0];
            bucket_pkg::IDX_MAXF:  next_cfg.max_fill    = i_wb_dat[7:0];
            bucket_pkg::IDX_DECAY: next_cfg.decay       = i_wb_dat[1:0];
            bucket_pkg::IDX_MASK:  next_mask            = i_wb_dat[1:0];
            default: begin
            end
         endcase
      end
      if (req && !i_wb_we) begin
         unique case (idx)
            bucket_pkg::IDX_UPPER:  next_rdata = {24'h00_0000, cfg.upper};
            bucket_pkg::IDX_CLEAR:  next_rdata = {24'h00_0000, cfg.clear_level};
            bucket_pkg::IDX_MAXF:   next_rdata = {24'h00_0000, cfg.max_fill};
            bucket_pkg::IDX_DECAY:  next_rdata = {30'h0000_0000, cfg.decay};
            bucket_pkg::IDX_STATUS: next_rdata = {30'h0000_0000, status};
            bucket_pkg::IDX_MASK:   next_rdata = {30'h0000_0000, mask};
            bucket_pkg::IDX_FILL:   next_rdata = {23'h00_0000, alarm, fill};
            default:                next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cfg.upper       <= bucket_pkg::RST_UPPER;
         cfg.clear_level <= bucket_pkg::RST_CLEAR;
         cfg.max_fill    <= bucket_pkg::RST_MAXF;
         cfg.decay       <= bucket_pkg::RST_DECAY;
         status          <= 2'h0;
         mask            <= bucket_pkg::RST_MASK;
         rdata           <= 32'h0000_0000;
         ack             <= 1'b0;
         tick_cnt        <= 6'h00;
      end else begin
         cfg      <= next_cfg;
         status   <= next_status;
         mask     <= next_mask;
         rdata    <= next_rdata;
         ack      <= next_ack;
         tick_cnt <= next_tick_cnt;
      end
   end

   assign o_wb_dat = rdata;
   assign o_wb_ack = ack;
   assign o_alarm  = alarm;
   assign o_irq    = |(status & mask);
endmodule
`default_nettype wire

/* File: tb/bucket_monitor_checker.sv */
// Concurrent checks of the leaky bucket monitor ports.
`timescale 1ns/1ns
`default_nettype none
module bucket_monitor_checker (
   // Bus and pins of the monitor.
   input wire logic        i_clk,
   input wire logic        i_srst,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [31:0] i_wb_adr,
   input wire logic [31:0] o_wb_dat,
   input wire logic        o_wb_ack,
   input wire logic        i_fault,
   input wire logic        o_alarm,
   input wire logic        o_irq
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_srst);
   // High until software first writes anything, so reads still show reset values.
   logic fresh;
   logic next_fresh;
   always_comb begin
      next_fresh = fresh && !(i_wb_cyc && i_wb_stb && i_wb_we);
   end
   always_ff @(posedge i_clk) begin
      fresh <= i_srst ? 1'b1 : next_fresh;
   end
   a_ack_one_cycle: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("ack late");
   a_ack_is_pulse: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held");
   a_reset_quiet: assert property (disable iff (1'b0) i_srst |=> !o_wb_ack && !o_alarm && !o_irq)
      else $error("outputs active after reset");
   a_clear_reset_value: assert property (o_wb_ack && !i_wb_we && fresh && i_wb_adr[9:2] == bucket_pkg::IDX_CLEAR |->
      o_wb_dat == {24'h0, bucket_pkg::RST_CLEAR}) else $error("clear level reset value");
   a_max_reset_value: assert property (o_wb_ack && !i_wb_we && fresh && i_wb_adr[9:2] == bucket_pkg::IDX_MAXF |->
      o_wb_dat == {24'h0, bucket_pkg::RST_MAXF}) else $error("max fill reset value");
   a_alarm_needs_fault: assert property ($rose(o_alarm) |->
      $past(i_fault, 2) || $past(i_fault, 3) || $past(i_fault, 4)) else $error("alarm without fault");
   a_alarm_held_fault: assert property (i_fault [*5] |=> !$fell(o_alarm))
      else $error("alarm cleared under fault");
endmodule
bind bucket_monitor bucket_monitor_checker bucket_monitor_checker_i (.*);
`default_nettype wire

/* File: tb/bucket_monitor_tb_top.sv */
// Self-checking bench for the leaky bucket monitor.
`timescale 1ns/1ns
`default_nettype none
module bucket_monitor_tb_top;
   logic        i_clk = 1'b0;
   logic        i_srst = 1'b1;
   logic        i_wb_cyc = 1'b0;
   logic        i_wb_stb = 1'b0;
   logic        i_wb_we = 1'b0;
   logic        i_fault = 1'b0;
   logic [31:0] i_wb_adr = '0;
   logic [31:0] i_wb_dat = '0;
   logic [3:0]  i_wb_sel = 4'hf;
   logic [31:0] o_wb_dat;
   logic        o_wb_ack;
   logic        o_alarm;
   logic        o_irq;
   logic [31:0] exp_q[$];
   logic [7:0]  rv;
   int          error_cnt = 0;
   int          check_count = 0;
   int          cyc_n = 0;
   int          t;
   always #10 i_clk = ~i_clk;
   bucket_monitor bucket_monitor_i (.*);
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      if (error_cnt == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // A read notes its expected word; the watcher below compares it when ack comes.
   task automatic bus(input logic we, input logic [7:0] idx, input logic [31:0] d);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= {22'h0, idx, 2'h0};
      i_wb_dat <= d;
      if (!we) exp_q.push_back(d);
      do @(posedge i_clk); while (o_wb_ack !== 1'b1);
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      @(posedge i_clk);
   endtask
   always @(posedge i_clk) begin
      if (o_wb_ack === 1'b1 && !i_wb_we) cmp(o_wb_dat, exp_q.pop_front());
   end
   always @(posedge i_clk) begin
      cyc_n++;
      if (cyc_n > 20000) begin
         error_cnt++;
         results();
      end
   end
   initial begin
      rv = $urandom(32'h9c8b);
      repeat (3) @(posedge i_clk);
      i_srst <= 1'b0;
      @(posedge i_clk);
      bus(1'b0, 8'h51, 32'h0000_0004);
      bus(1'b0, 8'h52, 32'h0000_0008);
      bus(1'b0, 8'h70, 32'h0000_0000);
      bus(1'b0, bucket_pkg::IDX_UPPER, {24'h00_0000, bucket_pkg::RST_UPPER});
      // A write without the low byte lane must leave the register alone.
      i_wb_sel <= 4'he;
      bus(1'b1, 8'h51, 32'h0000_00ff);
      bus(1'b0, 8'h51, 32'h0000_0004);
      i_wb_sel <= 4'hf;
      bus(1'b1, 8'h51, {24'h0, rv});
      bus(1'b0, 8'h51, {24'h0, rv});
      bus(1'b1, 8'h51, 32'h0000_0004);
      bus(1'b1, 8'h61, 32'h0000_0003);
      for (int d = 0; d < 4; d++) begin
         int e;
         e = 200 << d;
         bus(1'b1, 8'h53, d);
         i_fault <= 1'b1;
         repeat (600) @(posedge i_clk);
         bus(1'b0, 8'h62, 32'h0000_0108);
         cmp(o_irq, 1'b1);
         bus(1'b1, 8'h60, 32'h0000_0003);
         cmp(o_irq, 1'b0);
         i_fault <= 1'b0;
         t = 0;
         // The fault edge lands at an unknown tick phase, so the window spans one tick.
         while (o_alarm === 1'b1 && t < 3000) begin
            @(posedge i_clk);
            t++;
         end
         cmp(t >= e - 48 && t <= e + 8, 1'b1);
         bus(1'b0, 8'h62, 32'h0000_0004);
      end
      results();
   end
endmodule
`default_nettype wire
